// file: verilog/tsc_pkg.sv
// shared constants, types and register map of the transparent channel register bank
package tsc_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12; // byte address width on apb
	localparam int DATA_W = 32; // apb data width
	localparam int WORD_SHIFT = 2; // byte address = index * 4

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] MODE_IDX = 12'h000; // transparent_mode_control
	localparam logic [ADDR_W-1:0] EVENT_IDX = 12'h001; // channel_event_flags
	localparam logic [ADDR_W-1:0] ENABLE_IDX = 12'h002; // channel_event_enable
	localparam logic [ADDR_W-1:0] PARAM_IDX_FIRST = 12'h09c; // first reserved word
	localparam logic [ADDR_W-1:0] PARAM_IDX_LAST = 12'h0be; // last reserved word
	localparam logic [ADDR_W-1:0] MODE_ADDR = 12'(MODE_IDX << WORD_SHIFT);
	localparam logic [ADDR_W-1:0] EVENT_ADDR = 12'(EVENT_IDX << WORD_SHIFT);
	localparam logic [ADDR_W-1:0] ENABLE_ADDR = 12'(ENABLE_IDX << WORD_SHIFT);
	localparam logic [ADDR_W-1:0] PARAM_ADDR_FIRST = 12'(PARAM_IDX_FIRST << WORD_SHIFT);
	localparam logic [ADDR_W-1:0] PARAM_ADDR_LAST = 12'(PARAM_IDX_LAST << WORD_SHIFT);

	// ----------------------------------------------------------------
	// reserved parameter area: word-wide entries two indices apart
	// ----------------------------------------------------------------
	localparam int PARAM_DEPTH = 18; // 9c..be in steps of two
	localparam int PARAM_AW = 5; // index into the reserved words
	localparam int PARAM_W = 16; // each entry is one word
	localparam int PARAM_STEP_LSB = 3; // byte step between entries is 8
	localparam logic [PARAM_STEP_LSB-1:0] PARAM_ALIGN = 3'h0;

	// ----------------------------------------------------------------
	// register widths and reset values
	// ----------------------------------------------------------------
	localparam int MODE_W = 16;
	localparam int EVENT_W = 8;
	localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
	localparam logic [EVENT_W-1:0] EVENT_RST = 8'h00;
	localparam logic [EVENT_W-1:0] ENABLE_RST = 8'h00;
	localparam logic [EVENT_W-1:0] EVENT_USED = 8'hdf; // bit 5 has no event

	// mode register layout, msb first
	typedef struct packed {
		logic rsv15; // undefined, software writes zero
		logic external_sync_select; // bit 14
		logic no_transmit_sync; // bit 13
		logic reverse_data_order; // bit 12
		logic [5:0] rsv11_6; // undefined, software writes zero
		logic [5:0] common_mode; // common channel settings, bits 5..0
	} mode_reg_t;

	// event flags and enables share this layout, msb first
	typedef struct packed {
		logic cts_change; // bit 7
		logic cd_change; // bit 6
		logic unused5; // bit 5, never set
		logic transmit_error_flag; // bit 4
		logic character_received_flag; // bit 3
		logic receiver_busy_flag; // bit 2
		logic tx_buffer_done; // bit 1
		logic rx_buffer_done; // bit 0
	} event_set_t;

	// apb answer state, one-hot
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_FETCH = 3'b010,
		BUS_ANSWER = 3'b100
	} bus_state_t;

endpackage

// file: verilog/event_flag_bank.sv
// sticky write-one-to-clear flag bank
`timescale 1ns/1ps
module event_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] USED = '1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] set, // one-cycle event pulses
	input wire logic [W-1:0] clr, // ones clear, already gated by the write strobe
	output logic [W-1:0] flags_q
);
	logic [W-1:0] flags_d;

	// ----------------------------------------------------------------
	// next value: set wins over a clear in the same cycle
	// ----------------------------------------------------------------
	assign flags_d = ((flags_q & ~clr) | set) & USED; // RQ5 RQ7 RQ13

	// flag storage
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_q <= RST; // RQ8
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	flag_set_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
		(|(set & USED)) |=> ((flags_q & $past(set & USED)) == $past(set & USED)))
		else $error("event did not set its flag");
	flag_clear_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
		(set == '0) |=> (flags_q == ($past(flags_q) & ~$past(clr))))
		else $error("write-one clear misbehaved");
	flag_reset_a: assert property (@(posedge mclk) $fell(rst) |-> flags_q == RST) // RQ8
		else $error("flags not cleared by reset");
endmodule

// file: verilog/param_word_ram.sv
// small word store for the reserved parameter area
`timescale 1ns/1ps
module param_word_ram #(
	parameter int DEPTH = 18,
	parameter int AW = 5,
	parameter int W = 16
) (
	input wire logic mclk,
	input wire logic we, // one-cycle write strobe
	input wire logic [AW-1:0] addr, // shared read and write index
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata_q // registered read data
);
	logic [W-1:0] mem [DEPTH]; // contents are undefined until written

	// ----------------------------------------------------------------
	// write port and registered read
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_q <= mem[addr];
	end
endmodule

// file: verilog/transparent_serial_channel_regs.sv
// apb register bank of one serial channel in transparent mode
//
// What this block does
// (RQ1) sixteen-bit read-write mode register, protocol bits above
// (RQ2) reset clears every protocol-specific mode bit
// (RQ3) software writes zero to undefined mode bits
// (RQ4) sync select, no-transmit-sync, reverse order at 14..12
// (RQ5) eight sticky event flags set by channel
// (RQ6) event flag layout fixed, bit 5 unused
// (RQ7) writing one clears a flag, zero keeps
// (RQ8) reset clears all event flags
// (RQ9) eight-bit enable register, one unmasks its event
// (RQ10) reset clears enables, all events masked
// (RQ11) parameter area 9c..be reserved, never used internally
// (RQ12) request holds until unmasked flags are cleared
// (RQ13) one write may clear several flags
// (RQ14) request when any flag meets its enable
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module transparent_serial_channel_regs (
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tsc_pkg::ADDR_W-1:0] paddr,
	input wire logic [tsc_pkg::DATA_W-1:0] pwdata,
	output logic [tsc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel side
	input wire tsc_pkg::event_set_t channel_events, // one-cycle pulses
	output tsc_pkg::mode_reg_t mode_ctl, // mode register contents
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tsc_pkg::bus_state_t st_q; // apb answer sequencer
	tsc_pkg::bus_state_t st_d;
	tsc_pkg::mode_reg_t mode_q; // mode register storage
	logic [tsc_pkg::EVENT_W-1:0] enable_q; // interrupt enables
	logic [tsc_pkg::EVENT_W-1:0] flags; // sticky event flags
	logic [tsc_pkg::DATA_W-1:0] prdata_q;
	logic [tsc_pkg::DATA_W-1:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic irq_q;
	logic [tsc_pkg::PARAM_W-1:0] param_rdata; // registered by the ram

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire hit_mode = (paddr == tsc_pkg::MODE_ADDR);
	wire hit_event = (paddr == tsc_pkg::EVENT_ADDR);
	wire hit_enable = (paddr == tsc_pkg::ENABLE_ADDR);
	// offset within the reserved parameter area
	wire [tsc_pkg::ADDR_W-1:0] param_off = paddr - tsc_pkg::PARAM_ADDR_FIRST;
	// entries sit every eight bytes; odd indices are not mapped
	wire hit_param = (paddr >= tsc_pkg::PARAM_ADDR_FIRST)
		&& (paddr <= tsc_pkg::PARAM_ADDR_LAST)
		&& (param_off[tsc_pkg::PARAM_STEP_LSB-1:0] == tsc_pkg::PARAM_ALIGN);
	wire [tsc_pkg::PARAM_AW-1:0] param_idx =
		param_off[tsc_pkg::PARAM_STEP_LSB +: tsc_pkg::PARAM_AW];
	wire hit_any = hit_mode || hit_event || hit_enable || hit_param;

	// ----------------------------------------------------------------
	// transfer phases
	// ----------------------------------------------------------------
	// setup seen while idle starts the two-step answer
	wire setup = (st_q == tsc_pkg::BUS_IDLE) && psel && !penable;
	// the edge where the master samples pready high
	wire commit = (st_q == tsc_pkg::BUS_ANSWER) && psel && penable;
	wire wr_commit = commit && pwrite;
	// unmapped writes are dropped and flagged with pslverr
	wire wr_mode = wr_commit && hit_mode;
	wire wr_event = wr_commit && hit_event;
	wire wr_enable = wr_commit && hit_enable;
	wire wr_param = wr_commit && hit_param;

	// ----------------------------------------------------------------
	// read data selection
	// ----------------------------------------------------------------
	// narrow registers sit in the low bits, upper bits read zero
	wire [tsc_pkg::DATA_W-1:0] rd_mode =
		{{(tsc_pkg::DATA_W-tsc_pkg::MODE_W){1'b0}}, mode_q};
	wire [tsc_pkg::DATA_W-1:0] rd_event =
		{{(tsc_pkg::DATA_W-tsc_pkg::EVENT_W){1'b0}}, flags};
	wire [tsc_pkg::DATA_W-1:0] rd_enable =
		{{(tsc_pkg::DATA_W-tsc_pkg::EVENT_W){1'b0}}, enable_q};
	wire [tsc_pkg::DATA_W-1:0] rd_param =
		{{(tsc_pkg::DATA_W-tsc_pkg::PARAM_W){1'b0}}, param_rdata};
	wire [tsc_pkg::DATA_W-1:0] rd_mux =
		hit_mode ? rd_mode :
		hit_event ? rd_event :
		hit_enable ? rd_enable :
		hit_param ? rd_param : '0;

	// ----------------------------------------------------------------
	// apb sequencer
	// ----------------------------------------------------------------
	// the extra fetch step lets the ram read land in a register first,
	// so prdata stays a flop at the cost of one wait cycle
	always_comb begin
		st_d = st_q;
		prdata_d = prdata_q;
		pready_d = pready_q;
		pslverr_d = pslverr_q;
		unique case (st_q)
			tsc_pkg::BUS_IDLE: begin
				// wait for a setup cycle
				if (setup) begin
					st_d = tsc_pkg::BUS_FETCH;
				end
			end
			tsc_pkg::BUS_FETCH: begin
				// ram data now valid; present the answer
				st_d = tsc_pkg::BUS_ANSWER;
				prdata_d = pwrite ? '0 : rd_mux;
				pready_d = 1'b1;
				pslverr_d = !hit_any;
			end
			tsc_pkg::BUS_ANSWER: begin
				// answer stands until the master takes it
				if (commit) begin
					st_d = tsc_pkg::BUS_IDLE;
					prdata_d = '0;
					pready_d = 1'b0;
					pslverr_d = 1'b0;
				end
			end
			default: begin
				// illegal code: fall back to idle
				st_d = tsc_pkg::BUS_IDLE;
				prdata_d = '0;
				pready_d = 1'b0;
				pslverr_d = 1'b0;
			end
		endcase
	end

	// sequencer and answer flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= tsc_pkg::BUS_IDLE;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	// all sixteen bits are stored as written; undefined bits are the
	// writer's duty to keep at zero, so they are not forced here
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q <= tsc_pkg::MODE_RST; // RQ2
		end else if (wr_mode) begin
			mode_q <= pwdata[tsc_pkg::MODE_W-1:0]; // RQ1 RQ4
		end
	end

	// ----------------------------------------------------------------
	// interrupt enable register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_q <= tsc_pkg::ENABLE_RST; // RQ10
		end else if (wr_enable) begin
			enable_q <= pwdata[tsc_pkg::EVENT_W-1:0]; // RQ9
		end
	end

	// ----------------------------------------------------------------
	// sticky event flags
	// ----------------------------------------------------------------
	// clear vector only exists during an event register write
	wire [tsc_pkg::EVENT_W-1:0] ev_clr =
		wr_event ? pwdata[tsc_pkg::EVENT_W-1:0] : '0; // RQ7 RQ13
	wire [tsc_pkg::EVENT_W-1:0] ev_set = channel_events; // RQ6

	event_flag_bank #(
		.W(tsc_pkg::EVENT_W),
		.USED(tsc_pkg::EVENT_USED),
		.RST(tsc_pkg::EVENT_RST)
	) u_flags (
		.mclk(mclk),
		.rst(rst),
		.set(ev_set),
		.clr(ev_clr),
		.flags_q(flags)
	);

	// ----------------------------------------------------------------
	// reserved parameter words
	// ----------------------------------------------------------------
	// plain storage for software; nothing in the channel reads it
	param_word_ram #(
		.DEPTH(tsc_pkg::PARAM_DEPTH),
		.AW(tsc_pkg::PARAM_AW),
		.W(tsc_pkg::PARAM_W)
	) u_param (
		.mclk(mclk),
		.we(wr_param), // RQ11
		.addr(param_idx),
		.wdata(pwdata[tsc_pkg::PARAM_W-1:0]),
		.rdata_q(param_rdata)
	);

	// ----------------------------------------------------------------
	// interrupt request
	// ----------------------------------------------------------------
	// one cycle behind the flags; stays up while any enabled flag is set
	wire irq_d = |(flags & enable_q); // RQ12 RQ14

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign mode_ctl = mode_q;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// a write request held through the access phase
	sequence wr_access_s(logic hit);
		psel && !penable && pwrite && hit ##1 (psel && penable)[*2];
	endsequence

	// answer comes exactly two cycles after setup
	sequence answer_s;
		!pready ##1 pready;
	endsequence

	apb_answer_a: assert property (@(posedge mclk) disable iff (rst)
		setup |=> answer_s)
		else $error("pready not two cycles after setup");

	mode_write_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
		wr_access_s(hit_mode) |=> mode_ctl == $past(pwdata[15:0]))
		else $error("mode register did not take write");

	mode_reset_a: assert property (@(posedge mclk) // RQ2
		$fell(rst) |-> (mode_ctl == tsc_pkg::MODE_RST) && !irq)
		else $error("mode register not cleared by reset");

	mode_fields_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
		wr_mode |=> mode_ctl.external_sync_select == $past(pwdata[14])
			&& mode_ctl.no_transmit_sync == $past(pwdata[13])
			&& mode_ctl.reverse_data_order == $past(pwdata[12]))
		else $error("mode control bits misplaced");

	unused_bit_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
		!flags[5])
		else $error("unused event bit set");

	set_over_clear_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
		(wr_event && channel_events.tx_buffer_done && pwdata[1])
			|=> flags[1])
		else $error("clear beat a simultaneous event");

	multi_clear_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
		(wr_event && channel_events == '0)
			|=> (flags & $past(pwdata[7:0])) == '0)
		else $error("multi-bit clear left flags set");

	enable_rw_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
		wr_enable |=> ##2 (enable_q == $past(pwdata[7:0], 3)))
		else $error("enable register did not take write");

	enable_reset_a: assert property (@(posedge mclk) // RQ10
		$fell(rst) |-> enable_q == tsc_pkg::ENABLE_RST)
		else $error("enables not cleared by reset");

	irq_raise_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
		(|(flags & enable_q)) |=> irq)
		else $error("enabled flag did not raise irq");

	irq_masked_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
		((flags & enable_q) == '0) |=> !irq)
		else $error("irq raised with no enabled flag");

	irq_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
		irq && (flags & enable_q) != '0 |=> irq)
		else $error("irq dropped before flags cleared");

	param_isolated_a: assert property (@(posedge mclk) disable iff (rst) // RQ11
		wr_param |=> $stable(mode_ctl) && $stable(enable_q))
		else $error("reserved area write touched control state");

	// ----------------------------------------------------------------
	// answer shape and write isolation
	// ----------------------------------------------------------------
	// the answer stands for one cycle when the master holds psel and penable;
	// it waits in BUS_ANSWER for commit, so a late master still takes it
	ready_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		pready |=> !pready)
		else $error("pready stood longer than one cycle");

	// an error answer never comes without ready
	error_with_ready_a: assert property (@(posedge mclk) disable iff (rst)
		pslverr |-> pready)
		else $error("pslverr without pready");

	// read data is zero whenever no answer stands
	rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
		!pready |-> prdata == '0)
		else $error("prdata not zero outside an answer");

	// registers move only on their own committed write
	mode_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
		!wr_mode |=> $stable(mode_ctl))
		else $error("mode register changed without a write");

	enable_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
		!wr_enable |=> $stable(enable_q))
		else $error("enables changed without a write");

	// a dropped write to an unmapped address leaves control state alone
	unmapped_drop_a: assert property (@(posedge mclk) disable iff (rst)
		commit && !hit_any |=> $stable(mode_ctl) && $stable(enable_q))
		else $error("unmapped write touched control state");

endmodule

// file: tb/channel_peer.sv
// far-side model: the serial line raising channel events as one-cycle pulses
`timescale 1ns/1ps
module channel_peer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fire, // request from the bench
	input wire logic [7:0] pattern, // events to raise together
	output tsc_pkg::event_set_t channel_events
);
	// ----------------------------------------------------------------
	// event pulse source
	// ----------------------------------------------------------------
	// a pulse lasts one cycle only, never a level
	// so a sticky flag is owed to the bank, not to us
	always_ff @(posedge mclk) begin
		if (rst) begin
			channel_events <= '0; // quiet line in reset
		end else if (fire) begin
			channel_events <= pattern;
		end else begin
			channel_events <= '0;
		end
	end
endmodule

// file: tb/testbench.sv
// self-checking bench of the transparent channel register bank
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [tsc_pkg::ADDR_W-1:0] paddr = '0;
	logic [tsc_pkg::DATA_W-1:0] pwdata = '0;
	logic [tsc_pkg::DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic fire = 1'b0; // peer request
	logic [7:0] pattern = 8'h00; // peer event set
	tsc_pkg::event_set_t channel_events;
	tsc_pkg::mode_reg_t mode_ctl;
	logic irq;
	logic [31:0] rdv; // last read data
	logic errv; // last error answer
	int n_errors = 0;
	int total_checks = 0;

	// ----------------------------------------------------------------
	// clock, design and partner
	// ----------------------------------------------------------------
	// 200 MHz, 5 ns period
	initial begin
		forever #2.5 mclk = ~mclk;
	end

	transparent_serial_channel_regs DUT (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channel_events(channel_events), .mode_ctl(mode_ctl), .irq(irq));

	channel_peer peer (.mclk(mclk), .rst(rst), .fire(fire), .pattern(pattern),
		.channel_events(channel_events));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// verdict in one place only
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
	endtask

	// one apb transfer; the wait for pready is bounded
	task automatic apb(input logic wr, input logic [tsc_pkg::ADDR_W-1:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			if (n == 20) begin
				n_errors++; // slave never answered
				end_of_test();
			end
			n++;
			@(posedge mclk);
		end
		rdv = prdata; // taken at the pready edge only
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [tsc_pkg::ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// read, compare data, and compare the error answer
	task automatic rd_chk(input logic [tsc_pkg::ADDR_W-1:0] a, input logic [31:0] exp,
		input logic err);
		apb(1'b0, a, 32'h0);
		check(rdv, exp);
		check({31'h0, errv}, {31'h0, err});
	endtask

	// peer fires, then flag and irq settle
	task automatic pulse(input logic [7:0] p);
		@(posedge mclk);
		fire <= 1'b1;
		pattern <= p;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, {31'h0, exp});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// reset values of all three registers
		rd_chk(tsc_pkg::MODE_ADDR, 32'h0, 1'b0);
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0, 1'b0);
		rd_chk(tsc_pkg::ENABLE_ADDR, 32'h0, 1'b0);
		$display("test reset values done");

		// each control bit alone, undefined bits written as zero
		for (int i = 12; i < 15; i++) begin
			wr(tsc_pkg::MODE_ADDR, 32'h1 << i);
			rd_chk(tsc_pkg::MODE_ADDR, 32'h1 << i, 1'b0);
			check({31'h0, mode_ctl.external_sync_select}, 32'(i == 14));
			check({31'h0, mode_ctl.no_transmit_sync}, 32'(i == 13));
			check({31'h0, mode_ctl.reverse_data_order}, 32'(i == 12));
		end
		wr(tsc_pkg::MODE_ADDR, 32'h0000_702a);
		@(posedge mclk); // mode_ctl moves at the commit edge itself
		check({16'h0, mode_ctl}, 32'h0000_702a);
		$display("test mode register done");

		// all events at once; bit 5 has no event, all masked
		pulse(8'hff);
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00df, 1'b0);
		check({31'h0, irq}, 32'h0);
		wr(tsc_pkg::EVENT_ADDR, 32'h0); // zero writes keep flags
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00df, 1'b0);
		// each used bit raises irq once unmasked
		for (int i = 0; i < 8; i++) begin
			wr(tsc_pkg::ENABLE_ADDR, 32'h1 << i);
			irq_chk(i != 5);
		end
		wr(tsc_pkg::ENABLE_ADDR, 32'h0000_001c);
		rd_chk(tsc_pkg::ENABLE_ADDR, 32'h0000_001c, 1'b0);
		$display("test event and mask done");

		// clearing: several at once, irq holds until last unmasked one
		wr(tsc_pkg::EVENT_ADDR, 32'h0000_0011); // clears 4 and 0 together
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00ce, 1'b0);
		irq_chk(1'b1);
		wr(tsc_pkg::EVENT_ADDR, 32'h0000_0004);
		irq_chk(1'b1);
		wr(tsc_pkg::EVENT_ADDR, 32'h0000_0008);
		irq_chk(1'b0);
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00c2, 1'b0);
		pulse(8'h08); // flag sets again after clear
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00ca, 1'b0);
		irq_chk(1'b1);
		// an event and its clear in one cycle: the set wins
		// the peer pulse is timed to reach the bank on the commit edge
		fork
			wr(tsc_pkg::EVENT_ADDR, 32'h0000_0002);
			begin
				repeat (2) @(posedge mclk);
				fire <= 1'b1;
				pattern <= 8'h02;
				@(posedge mclk);
				fire <= 1'b0;
			end
		join
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00ca, 1'b0);
		$display("test clear and interrupt done");

		// reserved area: storage only, nothing else moves
		wr(tsc_pkg::PARAM_ADDR_FIRST, 32'h0000_1234);
		wr(tsc_pkg::PARAM_ADDR_LAST, 32'h0000_abcd);
		rd_chk(tsc_pkg::PARAM_ADDR_FIRST, 32'h0000_1234, 1'b0);
		rd_chk(tsc_pkg::PARAM_ADDR_LAST, 32'h0000_abcd, 1'b0);
		check({16'h0, mode_ctl}, 32'h0000_702a);
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0000_00ca, 1'b0);
		// odd index in the area and a hole after the enables are unmapped
		wr(12'h274, 32'h0000_5555);
		check({31'h0, errv}, 32'h1);
		rd_chk(12'h274, 32'h0, 1'b1);
		rd_chk(12'h00c, 32'h0, 1'b1);
		$display("test reserved area done");

		// second reset in mid-run, flags and enables live
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check({16'h0, mode_ctl}, 32'h0);
		check({31'h0, irq}, 32'h0);
		rd_chk(tsc_pkg::EVENT_ADDR, 32'h0, 1'b0);
		rd_chk(tsc_pkg::ENABLE_ADDR, 32'h0, 1'b0);
		$display("test second reset done");
		end_of_test();
	end
endmodule
